/* File: verilog/pcdt_pkg.sv */
// Constants shared by the prescaled countdown timer
package pcdt_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int PCDT_AW = 8;
   localparam logic [7:0] PCDT_OFS_CSR = 8'h0D;
   localparam logic [7:0] PCDT_OFS_VALUE = 8'h0E;

   // ************************************************************
   // Control/status fields
   // ************************************************************
   localparam int PCDT_BIT_FLAG = 7;
   localparam int PCDT_BIT_FLAG_CLR = 6;
   localparam int PCDT_BIT_IE = 5;
   localparam int PCDT_BIT_EN = 4;
   localparam int PCDT_PS_LSB = 0;
   localparam int PCDT_PS_W = 3;
   localparam int PCDT_DIV_W = 7;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [2:0] PCDT_PS_RESET = 3'h4;
   localparam logic [7:0] PCDT_COUNT_POR = 8'hFF;
   localparam logic [7:0] PCDT_COUNT_ONE = 8'h01;
   localparam logic [7:0] PCDT_COUNT_ZERO = 8'h00;
   localparam logic [7:0] PCDT_RD_IDLE = 8'h00;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int PCDT_STAB_CYCLES = 64;
   localparam int PCDT_STAB_W = 16;

endpackage : pcdt_pkg

/* File: verilog/pcdt_ctl_if.sv */
// Signals between the timer core, its prescaler and its stop control
`timescale 1ns/100ps
interface pcdt_ctl_if;
   logic run;
   logic clr;
   logic [2:0] sel;
   logic tick;
   logic stop_mode;
   logic halt;
   logic resume;

   modport core (output run, output clr, output sel, input tick,
      output stop_mode, input halt, input resume);
   modport presc (input run, input clr, input sel, output tick);
   modport stopc (input stop_mode, output halt, output resume);
endinterface : pcdt_ctl_if

/* File: verilog/pcdt_prescaler.sv */
// Power-of-two prescaler feeding the countdown counter
`timescale 1ns/100ps
module pcdt_prescaler
   import pcdt_pkg::*;
#(
   parameter int DIV_W = PCDT_DIV_W
) (
   input wire logic clock,
   input wire logic rst,
   pcdt_ctl_if.presc ctl
);

   typedef struct packed {
      logic [DIV_W-1:0] div;
   } pcdt_presc_t;

   pcdt_presc_t st_ff;
   pcdt_presc_t nxt_st;
   logic [DIV_W-1:0] mask;

   // Ratio 1 gives an empty mask, so every running cycle ticks
   assign mask = DIV_W'((DIV_W+1)'(1) << ctl.sel) - DIV_W'(1);
   assign ctl.tick = ctl.run & ((st_ff.div & mask) == mask);

   always_comb begin
      nxt_st = st_ff;
      if (ctl.clr) begin
         nxt_st.div = '0;
      end else if (ctl.run) begin
         nxt_st.div = st_ff.div + DIV_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : pcdt_prescaler

/* File: verilog/pcdt_stop_ctl.sv */
// Halts the timer in stop and times the stabilisation on exit
`timescale 1ns/100ps
module pcdt_stop_ctl
   import pcdt_pkg::*;
#(
   parameter int STAB_CYCLES = PCDT_STAB_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   pcdt_ctl_if.stopc ctl
);

   typedef enum logic [1:0] {RUNNING, STOPPED, STABILISE} pcdt_stop_st_t;

   typedef struct packed {
      pcdt_stop_st_t state;
      logic [PCDT_STAB_W-1:0] wait_cnt;
      logic resume;
   } pcdt_stop_t;

   pcdt_stop_t st_ff;
   pcdt_stop_t nxt_st;

   assign ctl.halt = (st_ff.state != RUNNING);
   assign ctl.resume = st_ff.resume;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.resume = 1'b0;
      case (st_ff.state)
         RUNNING: begin
            if (ctl.stop_mode) begin
               nxt_st.state = STOPPED;
            end
         end
         STOPPED: begin
            if (!ctl.stop_mode) begin
               nxt_st.state = STABILISE;
               nxt_st.wait_cnt = PCDT_STAB_W'(STAB_CYCLES - 1);
            end
         end
         STABILISE: begin
            if (st_ff.wait_cnt == '0) begin
               nxt_st.state = RUNNING;
               nxt_st.resume = 1'b1;
            end else begin
               nxt_st.wait_cnt = st_ff.wait_cnt - PCDT_STAB_W'(1);
            end
         end
         default: begin
            nxt_st.state = RUNNING;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_ff <= '{state: RUNNING, wait_cnt: '0, resume: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : pcdt_stop_ctl

/* File: verilog/pcdt_timer.sv */
// Prescaled 8-bit countdown timer with register port
// Notes on behaviour
// - eight-bit counter decrements per prescaler pulse
// - counter writes preset, reads return count
// - reaching zero sets the zero flag
// - interrupt request when flag and enable set
// - counting continues after zero is reached
// - reads never disturb counting; value stable
// - flag holds until cleared by write one or by a counter write
// - clear bit write-only, one clears, zero ignored
// - counter write discards a pending interrupt
// - flag readable as status without interrupts
// - counter clock is bus clock over ratio
// - select codes give ratios 1 to 128
// - reset selects divide by sixteen
// - enable bit gates timer, cleared by reset
// - power-on interval timed with full count
// - watchdog clock taken from counter zero events
// - stop halts; exit clears to zero, resumes
// - wait keeps counting; interrupt wakes processor
`timescale 1ns/100ps
module pcdt_timer
   import pcdt_pkg::*;
#(
   parameter int STAB_CYCLES = PCDT_STAB_CYCLES,
   parameter int DIV_W = PCDT_DIV_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [PCDT_AW-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic irq,
   output logic por_busy,
   output logic wd_tick,
   input wire logic stop_mode,
   input wire logic wait_mode,
   output logic wake
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [7:0] count;
      logic flag;
      logic ie;
      logic en;
      logic [PCDT_PS_W-1:0] ps;
      logic por_active;
      logic [7:0] rdata;
      logic wd_tick;
   } pcdt_core_t;

   // Power-on leaves the count full and the ratio at sixteen
   localparam pcdt_core_t PCDT_CORE_RST = '{
      count: PCDT_COUNT_POR,
      flag: 1'b0,
      ie: 1'b0,
      en: 1'b0,
      ps: PCDT_PS_RESET,
      por_active: 1'b1,
      rdata: PCDT_RD_IDLE,
      wd_tick: 1'b0
   };

   pcdt_core_t st_ff;
   pcdt_core_t nxt_st;

   pcdt_ctl_if ctl ();

   // ************************************************************
   // Decoded bus cycle
   // ************************************************************
   logic wr_csr;
   logic wr_value;
   logic rd_csr;
   logic rd_value;
   logic counting;
   logic zero_hit;
   logic [7:0] csr_view;

   assign wr_csr = wr && (addr == PCDT_OFS_CSR);
   assign wr_value = wr && (addr == PCDT_OFS_VALUE);
   assign rd_csr = rd && (addr == PCDT_OFS_CSR);
   assign rd_value = rd && (addr == PCDT_OFS_VALUE);

   // ************************************************************
   // Control/status view
   // ************************************************************
   // The clear bit has no storage and always reads back as zero
   always_comb begin
      csr_view = 8'h00;
      csr_view[PCDT_BIT_FLAG] = st_ff.flag;
      csr_view[PCDT_BIT_IE] = st_ff.ie;
      csr_view[PCDT_BIT_EN] = st_ff.en;
      csr_view[PCDT_PS_LSB +: PCDT_PS_W] = st_ff.ps;
   end

   // ************************************************************
   // Prescaler and stop control hookup
   // ************************************************************
   // The power-on interval runs even though software has not yet
   // set the enable bit
   assign counting = (st_ff.en | st_ff.por_active) & ~ctl.halt;
   // A preset restarts the divider so the first decrement after it
   // takes a full prescaler period
   assign ctl.run = counting & ~wr_value;
   assign ctl.clr = wr_value;
   assign ctl.sel = st_ff.ps;
   assign ctl.stop_mode = stop_mode;

   pcdt_prescaler #(
      .DIV_W(DIV_W)
   ) u_prescaler (
      .clock(clock),
      .rst(rst),
      .ctl(ctl.presc)
   );

   pcdt_stop_ctl #(
      .STAB_CYCLES(STAB_CYCLES)
   ) u_stop_ctl (
      .clock(clock),
      .rst(rst),
      .ctl(ctl.stopc)
   );

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rdata = PCDT_RD_IDLE;
      nxt_st.wd_tick = 1'b0;
      zero_hit = 1'b0;

      // Reads only sample; the count is never touched here
      if (rd_csr) begin
         nxt_st.rdata = csr_view;
      end else if (rd_value) begin
         nxt_st.rdata = st_ff.count;
      end

      // Control writes; the select field takes the written code
      if (wr_csr) begin
         nxt_st.ie = wdata[PCDT_BIT_IE];
         nxt_st.en = wdata[PCDT_BIT_EN];
         nxt_st.ps = wdata[PCDT_PS_LSB +: PCDT_PS_W];
      end

      // Counter update: stop exit first, then preset, then tick
      if (ctl.resume) begin
         nxt_st.count = PCDT_COUNT_ZERO;
         zero_hit = 1'b1;
      end else if (wr_value) begin
         nxt_st.count = wdata;
         nxt_st.flag = 1'b0;
      end else if (ctl.tick) begin
         // Wraps from zero to all ones and keeps going
         nxt_st.count = st_ff.count - PCDT_COUNT_ONE;
         zero_hit = (st_ff.count == PCDT_COUNT_ONE);
      end

      // Write-one clears; a zero in that bit does nothing
      if (wr_csr && wdata[PCDT_BIT_FLAG_CLR]) begin
         nxt_st.flag = 1'b0;
      end

      // A zero arrival in the clearing cycle still sets the flag
      if (zero_hit) begin
         nxt_st.flag = 1'b1;
         nxt_st.wd_tick = 1'b1;
      end

      // The first arrival at zero ends the power-on interval
      if (st_ff.por_active && zero_hit) begin
         nxt_st.por_active = 1'b0;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         st_ff <= PCDT_CORE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign rdata = st_ff.rdata;
   assign irq = st_ff.flag & st_ff.ie;
   assign por_busy = st_ff.por_active;
   assign wd_tick = st_ff.wd_tick;
   // Counting is unaffected by wait, so an enabled event wakes
   assign wake = wait_mode & st_ff.flag & st_ff.ie;

endmodule : pcdt_timer

/* File: bench/pcdt_timer_properties.sv */
// Port checks for the countdown timer
`timescale 1ns/100ps
module pcdt_timer_properties
   import pcdt_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [PCDT_AW-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic irq,
   input wire logic por_busy,
   input wire logic wd_tick,
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire logic wake
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_csr_wr; wr && addr == PCDT_OFS_CSR; endsequence
   sequence s_cnt_wr; wr && addr == PCDT_OFS_VALUE; endsequence
   sequence s_csr_rd; rd && addr == PCDT_OFS_CSR; endsequence
   sequence s_bad_rd;
      rd && addr != PCDT_OFS_CSR && addr != PCDT_OFS_VALUE;
   endsequence
   a_rdata_idle: assert property (!rd |=> rdata == PCDT_RD_IDLE)
      else $error("read data not idle");
   a_csr_holes: assert property (s_csr_rd |=> !rdata[6] && !rdata[3])
      else $error("write-only bit read back");
   a_unmapped_rd: assert property (s_bad_rd |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_clear_w1c: assert property (s_csr_wr ##0 wdata[PCDT_BIT_FLAG_CLR]
      |=> !irq || wd_tick) else $error("flag clear ignored");
   a_preset_drop: assert property (s_cnt_wr |=> !irq)
      else $error("preset kept interrupt");
   a_irq_cause: assert property ($rose(irq) |->
      wd_tick || $past(wr && addr == PCDT_OFS_CSR)) else $error("stray irq");
   a_wake_gate: assert property (wake == (wait_mode && irq))
      else $error("wake mismatch");
   a_tick_pulse: assert property (wd_tick |=> !wd_tick)
      else $error("tick longer than one cycle");
   a_por_ends: assert property ($fell(por_busy) |-> wd_tick)
      else $error("power-on end without zero");
   a_por_once: assert property (!por_busy |=> !por_busy)
      else $error("power-on busy came back");
endmodule : pcdt_timer_properties

/* File: bench/pcdt_timer_tb.sv */
// Self-checking bench for the countdown timer
`timescale 1ns/100ps
module pcdt_timer_tb
   import pcdt_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [PCDT_AW-1:0] addr = '0;
   logic [7:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic stop_mode = 1'b0;
   logic wait_mode = 1'b0;
   logic [7:0] rdata;
   logic irq, por_busy, wd_tick, wake;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   // Rows: select code i gives this divide ratio
   int ratio [8] = '{1, 2, 4, 8, 16, 32, 64, 128};
   // Short stabilisation keeps the stop exit quick
   pcdt_timer #(.STAB_CYCLES(2)) DUT (.clock(clock), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .irq(irq), .por_busy(por_busy), .wd_tick(wd_tick),
      .stop_mode(stop_mode), .wait_mode(wait_mode), .wake(wake));
   initial begin
      forever #20 clock = ~clock;
   end
   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input string what, input logic [7:0] a, exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk(what, rdata, exp);
   endtask : rd_reg
   // Bounded wait for the next zero arrival, n counts edges
   task automatic wait_tick();
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (wd_tick !== 1'b1 && n < 5000);
   endtask : wait_tick
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd_reg("csr rst", PCDT_OFS_CSR, 8'h04);
      rd_reg("cnt rst", PCDT_OFS_VALUE, 8'hFF);
      wait_tick();
      chk("por", {n < 5000, por_busy}, 2'b10);
      rd_reg("polled", PCDT_OFS_CSR, 8'h84);
      for (int i = 0; i < 8; i++) begin
         @(posedge clock) wait_mode <= i[0];
         wr_reg(PCDT_OFS_CSR, 8'h70 | 8'(i));
         wr_reg(PCDT_OFS_VALUE, 8'h03);
         wait_tick();
         chk("ratio", 16'(n), 16'(3 * ratio[i]));
         chk("irq", irq, 1'b1);
         chk("wake", wake, wait_mode);
         rd_reg("csr", PCDT_OFS_CSR, 8'hB0 | 8'(i));
      end
      rd_reg("at zero", PCDT_OFS_VALUE, 8'h00);
      repeat (130) @(posedge clock);
      rd_reg("wrap", PCDT_OFS_VALUE, 8'hFF);
      wr_reg(PCDT_OFS_CSR, 8'h37);
      rd_reg("w0", PCDT_OFS_CSR, 8'hB7);
      wr_reg(PCDT_OFS_CSR, 8'h77);
      rd_reg("w1", PCDT_OFS_CSR, 8'h37);
      wr_reg(PCDT_OFS_CSR, 8'h30);
      wr_reg(PCDT_OFS_VALUE, 8'h01);
      wait_tick();
      chk("irq", irq, 1'b1);
      wr_reg(PCDT_OFS_VALUE, 8'h80);
      #1 chk("lost", irq, 1'b0);
      wr_reg(8'h0C, 8'hFF);
      rd_reg("hole", 8'h0C, 8'h00);
      rd_reg("csr", PCDT_OFS_CSR, 8'h30);
      // Clear lands on the edge where the count reaches zero
      wr_reg(PCDT_OFS_VALUE, 8'h02);
      wr_reg(PCDT_OFS_CSR, 8'h70);
      rd_reg("set wins", PCDT_OFS_CSR, 8'hB0);
      wr_reg(PCDT_OFS_CSR, 8'h00);
      wr_reg(PCDT_OFS_VALUE, 8'h5A);
      repeat (300) @(posedge clock);
      rd_reg("held", PCDT_OFS_VALUE, 8'h5A);
      wr_reg(PCDT_OFS_CSR, 8'h17);
      wr_reg(PCDT_OFS_VALUE, 8'h40);
      @(posedge clock) stop_mode <= 1'b1;
      repeat (200) @(posedge clock);
      rd_reg("stop", PCDT_OFS_VALUE, 8'h40);
      @(posedge clock) stop_mode <= 1'b0;
      wait_tick();
      chk("resume", n < 20, 1'b1);
      rd_reg("cleared", PCDT_OFS_VALUE, 8'h00);
      @(posedge clock) rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd_reg("csr rst2", PCDT_OFS_CSR, 8'h04);
      chk("por2", por_busy, 1'b1);
      tally_and_finish();
   end
endmodule : pcdt_timer_tb
bind pcdt_timer pcdt_timer_properties u_props (.clock(clock), .rst(rst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .irq(irq), .por_busy(por_busy), .wd_tick(wd_tick),
   .stop_mode(stop_mode), .wait_mode(wait_mode), .wake(wake));
